// ---- hdl/loopback_pkg.sv ----
// constants for the serial adapter with echo path
package loopback_pkg;
    // ========================================
    // register addresses
    localparam logic [1:0] ADDR_DATA = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_CMD = 2'h2;
    localparam logic [1:0] ADDR_CTL = 2'h3;
    // ========================================
    // reset values
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [7:0] CTL_RST = 8'h00;
    // ========================================
    // field positions
    localparam int CMD_ENABLE = 0;
    localparam int CMD_RX_IRQ = 1;
    localparam int CMD_TX_LO = 2;
    localparam int CMD_TX_HI = 3;
    localparam int CMD_ECHO = 4;
    localparam int CTL_RX_SRC = 4;
    localparam int CTL_RATE_HI = 3;
    localparam int ST_FRAME = 1;
    localparam int ST_OVR = 2;
    localparam int ST_RDRF = 3;
    localparam int ST_TDRE = 4;
    localparam int ST_DCD = 5;
    localparam int ST_DSR = 6;
    localparam int ST_IRQ = 7;
    // ========================================
    // timing counts and command field codes
    localparam logic [3:0] TICKS_LAST = 4'hF;
    localparam logic [3:0] HALF_LAST = 4'h7;
    localparam logic [3:0] TX_LAST_BIT = 4'h9;
    localparam logic [3:0] RX_DATA_BITS = 4'h8;
    localparam logic [15:0] INT_DIV_LAST = 16'h005F;
    localparam logic [1:0] TX_ENABLED_IRQ = 2'h1;
    localparam logic [1:0] RTS_HIGH_CODE = 2'h0;
endpackage

// ---- hdl/baud_tick.sv ----
// oversampling tick source, external clock edge or internal divider
`timescale 1ns/10ps
module baud_tick
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // source select
    input wire logic i_sel_ext,
    input wire logic i_ext_clk,
    // tick out
    output logic o_tick
);
    // ========================================
    // edge detect and divider
    logic ext_d_r;
    logic ext_d_nxt;
    logic [15:0] div_r;
    logic [15:0] div_nxt;

    always_comb
    begin
        ext_d_nxt = i_ext_clk;
        if (i_sel_ext || div_r == loopback_pkg::INT_DIV_LAST)
        begin
            div_nxt = 16'h0000;
        end
        else
        begin
            div_nxt = div_r + 16'h0001;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ext_d_r <= ext_d_nxt;
            div_r <= 16'h0000;
        end
        else
        begin
            ext_d_r <= ext_d_nxt;
            div_r <= div_nxt;
        end
    end

    assign o_tick = i_sel_ext ? (i_ext_clk && !ext_d_r) : (div_r == loopback_pkg::INT_DIV_LAST);
endmodule // baud_tick

// ---- hdl/serial_loopback_diagnostics.sv ----
// serial adapter core with echo, plain register port and modem lines
//
// Overview of operation
// - the adapter has no local loop-back switch of its own; local loop-back steering lives outside.
// - control bit 4 set makes the receiver run on the transmitter's clock.
// - command bit 4 set selects echo mode.
// - command bits 3 and 2 at one and zero keep transmitter interrupts off.
// - command bit 1 at zero keeps receiver interrupts off.
// - in echo a received character is sent back at once if the transmitter is idle; it still loads the data register and sets RDRF.
// - on an external clock each bit lasts sixteen clock ticks.
// - with echo selected the request-to-send output is driven low.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
module serial_loopback_diagnostics
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // clocks
    input wire logic i_crystal_clock_input,
    input wire logic i_rx_clk_ext,
    // serial and modem lines
    input wire logic i_rxd,
    input wire logic i_dcd,
    input wire logic i_dsr,
    output logic o_txd,
    output logic o_rts,
    output logic o_dtr,
    output logic o_irq_n
);
    // ========================================
    // state types
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100} rx_state_t;

    logic [7:0] ctl_r, ctl_nxt, cmd_r, cmd_nxt, tdr_r, tdr_nxt, rdr_r, rdr_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt, rdata_r, rdata_nxt;
    logic [9:0] tx_sh_r, tx_sh_nxt;
    logic [3:0] tx_sub_r, tx_sub_nxt, tx_cnt_r, tx_cnt_nxt, rx_sub_r, rx_sub_nxt, rx_cnt_r, rx_cnt_nxt;
    logic tdre_r, tdre_nxt, rdrf_r, rdrf_nxt, ovr_r, ovr_nxt, fe_r, fe_nxt, rx_done_r, rx_done_nxt;
    logic txd_r, txd_nxt, rts_r, rts_nxt, dtr_r, dtr_nxt, irq_n_r, irq_n_nxt;
    tx_state_t tx_state_r, tx_state_nxt;
    rx_state_t rx_state_r, rx_state_nxt;
    logic tx_tick, rx_ext_tick, rx_tick, echo;

    // ========================================
    // tick sources
    baud_tick u_tx_tick
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_sel_ext(ctl_r[loopback_pkg::CTL_RATE_HI:0] == 4'h0),
        .i_ext_clk(i_crystal_clock_input),
        .o_tick(tx_tick)
    );

    baud_tick u_rx_tick
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_sel_ext(1'b1),
        .i_ext_clk(i_rx_clk_ext),
        .o_tick(rx_ext_tick)
    );

    assign rx_tick = ctl_r[loopback_pkg::CTL_RX_SRC] ? tx_tick : rx_ext_tick;
    assign echo = cmd_r[loopback_pkg::CMD_ECHO];

    // ========================================
    // next state
    always_comb
    begin
        ctl_nxt = ctl_r;
        cmd_nxt = cmd_r;
        tdr_nxt = tdr_r;
        rdr_nxt = rdr_r;
        rx_sh_nxt = rx_sh_r;
        tx_sh_nxt = tx_sh_r;
        tx_sub_nxt = tx_sub_r;
        tx_cnt_nxt = tx_cnt_r;
        rx_sub_nxt = rx_sub_r;
        rx_cnt_nxt = rx_cnt_r;
        tdre_nxt = tdre_r;
        rdrf_nxt = rdrf_r;
        ovr_nxt = ovr_r;
        fe_nxt = fe_r;
        rx_done_nxt = 1'b0;
        tx_state_nxt = tx_state_r;
        rx_state_nxt = rx_state_r;
        rdata_nxt = rdata_r;
        // host reads, clears come before hardware sets
        if (i_rd)
        begin
            case (i_addr)
                loopback_pkg::ADDR_DATA:
                begin
                    rdata_nxt = rdr_r;
                    rdrf_nxt = 1'b0;
                    ovr_nxt = 1'b0;
                    fe_nxt = 1'b0;
                end
                loopback_pkg::ADDR_STATUS:
                    rdata_nxt = {!irq_n_r, i_dsr, i_dcd, tdre_r, rdrf_r, ovr_r, fe_r, 1'b0};
                loopback_pkg::ADDR_CMD:
                    rdata_nxt = cmd_r;
                loopback_pkg::ADDR_CTL:
                    rdata_nxt = ctl_r;
                default:
                    rdata_nxt = 8'h00;
            endcase
        end
        // host writes; a status write is the program reset
        if (i_wr)
        begin
            case (i_addr)
                loopback_pkg::ADDR_DATA:
                begin
                    tdr_nxt = i_wdata;
                    tdre_nxt = 1'b0;
                end
                loopback_pkg::ADDR_STATUS:
                begin
                    cmd_nxt = {cmd_r[7:5], 5'h00};
                    ovr_nxt = 1'b0;
                end
                loopback_pkg::ADDR_CMD:
                    cmd_nxt = i_wdata;
                loopback_pkg::ADDR_CTL:
                    ctl_nxt = i_wdata;
                default:
                    ctl_nxt = ctl_r;
            endcase
        end
        // transmitter
        case (tx_state_r)
            TX_IDLE:
            begin
                tx_sub_nxt = 4'h0;
                tx_cnt_nxt = 4'h0;
                if (echo && rx_done_r)
                begin
                    tx_sh_nxt = {1'b1, rdr_r, 1'b0};
                    tx_state_nxt = TX_SHIFT;
                end
                else if (!echo && !tdre_r && cmd_r[loopback_pkg::CMD_ENABLE])
                begin
                    tx_sh_nxt = {1'b1, tdr_r, 1'b0};
                    tdre_nxt = 1'b1;
                    tx_state_nxt = TX_SHIFT;
                end
            end
            TX_SHIFT:
            begin
                if (tx_tick)
                begin
                    tx_sub_nxt = tx_sub_r + 4'h1;
                    if (tx_sub_r == loopback_pkg::TICKS_LAST)
                    begin
                        tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
                        tx_cnt_nxt = tx_cnt_r + 4'h1;
                        if (tx_cnt_r == loopback_pkg::TX_LAST_BIT)
                        begin
                            tx_state_nxt = TX_IDLE;
                        end
                    end
                end
            end
            default:
                tx_state_nxt = TX_IDLE;
        endcase
        // receiver
        case (rx_state_r)
            RX_IDLE:
            begin
                rx_sub_nxt = 4'h0;
                rx_cnt_nxt = 4'h0;
                if (rx_tick && !i_rxd && cmd_r[loopback_pkg::CMD_ENABLE])
                begin
                    rx_state_nxt = RX_START;
                end
            end
            RX_START:
            begin
                if (rx_tick)
                begin
                    rx_sub_nxt = rx_sub_r + 4'h1;
                    if (rx_sub_r == loopback_pkg::HALF_LAST)
                    begin
                        rx_sub_nxt = 4'h0;
                        rx_state_nxt = i_rxd ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA:
            begin
                if (rx_tick)
                begin
                    rx_sub_nxt = rx_sub_r + 4'h1;
                    if (rx_sub_r == loopback_pkg::TICKS_LAST)
                    begin
                        rx_cnt_nxt = rx_cnt_r + 4'h1;
                        if (rx_cnt_r == loopback_pkg::RX_DATA_BITS)
                        begin
                            rdr_nxt = rx_sh_r;
                            fe_nxt = !i_rxd;
                            ovr_nxt = ovr_nxt || rdrf_r;
                            rdrf_nxt = 1'b1;
                            rx_done_nxt = 1'b1;
                            rx_state_nxt = RX_IDLE;
                        end
                        else
                        begin
                            rx_sh_nxt = {i_rxd, rx_sh_r[7:1]};
                        end
                    end
                end
            end
            default:
                rx_state_nxt = RX_IDLE;
        endcase
        // pins
        txd_nxt = (tx_state_nxt == TX_SHIFT) ? tx_sh_nxt[0] : 1'b1;
        rts_nxt = !cmd_nxt[loopback_pkg::CMD_ECHO] &&
            (cmd_nxt[loopback_pkg::CMD_TX_HI:loopback_pkg::CMD_TX_LO] == loopback_pkg::RTS_HIGH_CODE);
        dtr_nxt = !cmd_nxt[loopback_pkg::CMD_ENABLE];
        irq_n_nxt = !((rdrf_nxt && cmd_nxt[loopback_pkg::CMD_RX_IRQ]) ||
            (tdre_nxt && cmd_nxt[loopback_pkg::CMD_TX_HI:loopback_pkg::CMD_TX_LO] ==
            loopback_pkg::TX_ENABLED_IRQ));
    end

    // ========================================
    // registers
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ctl_r <= loopback_pkg::CTL_RST;
            cmd_r <= loopback_pkg::CMD_RST;
            tdr_r <= 8'h00;
            rdr_r <= 8'h00;
            rx_sh_r <= 8'h00;
            tx_sh_r <= 10'h3FF;
            tx_sub_r <= 4'h0;
            tx_cnt_r <= 4'h0;
            rx_sub_r <= 4'h0;
            rx_cnt_r <= 4'h0;
            tdre_r <= 1'b1;
            rdrf_r <= 1'b0;
            ovr_r <= 1'b0;
            fe_r <= 1'b0;
            rx_done_r <= 1'b0;
            tx_state_r <= TX_IDLE;
            rx_state_r <= RX_IDLE;
            rdata_r <= 8'h00;
            txd_r <= 1'b1;
            rts_r <= 1'b1;
            dtr_r <= 1'b1;
            irq_n_r <= 1'b1;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            cmd_r <= cmd_nxt;
            tdr_r <= tdr_nxt;
            rdr_r <= rdr_nxt;
            rx_sh_r <= rx_sh_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_sub_r <= tx_sub_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            rx_sub_r <= rx_sub_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            tdre_r <= tdre_nxt;
            rdrf_r <= rdrf_nxt;
            ovr_r <= ovr_nxt;
            fe_r <= fe_nxt;
            rx_done_r <= rx_done_nxt;
            tx_state_r <= tx_state_nxt;
            rx_state_r <= rx_state_nxt;
            rdata_r <= rdata_nxt;
            txd_r <= txd_nxt;
            rts_r <= rts_nxt;
            dtr_r <= dtr_nxt;
            irq_n_r <= irq_n_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_txd = txd_r;
    assign o_rts = rts_r;
    assign o_dtr = dtr_r;
    assign o_irq_n = irq_n_r;

    // ========================================
    // checks
    property p_idle_line;
        @(posedge i_clk) disable iff (!i_rst_n)
        (tx_state_r == TX_IDLE && !echo) |-> o_txd;
    endproperty
    a_idle_line: assert property (p_idle_line) else $error("txd not idle high");

    property p_rx_src;
        @(posedge i_clk) disable iff (!i_rst_n)
        (ctl_r[loopback_pkg::CTL_RX_SRC] && rx_state_r != RX_IDLE && !tx_tick) |=> $stable(rx_sub_r);
    endproperty
    a_rx_src: assert property (p_rx_src) else $error("receiver not on transmitter clock");

    property p_echo_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == loopback_pkg::ADDR_CMD && i_wdata[loopback_pkg::CMD_ECHO]) |=> echo;
    endproperty
    a_echo_set: assert property (p_echo_set) else $error("echo not selected");

    property p_tx_irq_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        (cmd_r[loopback_pkg::CMD_TX_HI] && !cmd_r[loopback_pkg::CMD_TX_LO] &&
            !cmd_r[loopback_pkg::CMD_RX_IRQ]) |-> o_irq_n;
    endproperty
    a_tx_irq_off: assert property (p_tx_irq_off) else $error("transmit interrupt raised");

    property p_rx_irq_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        (rdrf_r && !cmd_r[loopback_pkg::CMD_RX_IRQ] &&
            cmd_r[loopback_pkg::CMD_TX_HI:loopback_pkg::CMD_TX_LO] != loopback_pkg::TX_ENABLED_IRQ) |-> o_irq_n;
    endproperty
    a_rx_irq_off: assert property (p_rx_irq_off) else $error("receive interrupt raised");

    property p_echo_send;
        @(posedge i_clk) disable iff (!i_rst_n)
        (echo && rx_done_r && tx_state_r == TX_IDLE) |=> tx_state_r == TX_SHIFT && tx_sh_r[8:1] == $past(rdr_r);
    endproperty
    a_echo_send: assert property (p_echo_send) else $error("echo character not sent");

    property p_bit_len;
        @(posedge i_clk) disable iff (!i_rst_n)
        (tx_state_r == TX_SHIFT && tx_tick && tx_sub_r != loopback_pkg::TICKS_LAST) |=> $stable(tx_cnt_r);
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("bit ended early");

    property p_rts_low;
        @(posedge i_clk) disable iff (!i_rst_n)
        echo |-> !o_rts;
    endproperty
    a_rts_low: assert property (p_rts_low) else $error("rts high in echo");
endmodule // serial_loopback_diagnostics

// ---- verif/modem_model.sv ----
// far-side model: modem line and the outside local loop steering
`timescale 1ns/10ps
module modem_model
#(
    parameter int BIT_CYC = 64
)
(
    // clock
    input wire logic i_clk,
    // steering control
    input wire logic i_local_loop_enable,
    // adapter side
    input wire logic i_txd,
    input wire logic i_rts,
    input wire logic i_dtr,
    output logic o_rxd,
    output logic o_dcd,
    output logic o_dsr,
    // capture results
    output logic [7:0] o_rx_byte,
    output int o_rx_count,
    output int o_last_low
);
    // ========================================
    // steering
    logic m_rxd = 1'b1;
    logic m_txd;
    int low_run = 0;
    // high level selects local loop, low passes lines through
    assign m_txd = i_local_loop_enable ? 1'b1 : i_txd;
    assign o_rxd = i_local_loop_enable ? i_txd : m_rxd;
    assign o_dcd = i_local_loop_enable ? i_dtr : 1'b0;
    assign o_dsr = i_local_loop_enable ? 1'b1 : 1'b0;
    // ========================================
    // modem transmitter, 8N1 lsb first
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge i_clk);
            m_rxd <= f[i];
            repeat (BIT_CYC - 1) @(posedge i_clk);
        end
    endtask
    // ========================================
    // modem receiver and low run length
    initial
    begin
        o_rx_byte = 8'h00;
        o_rx_count = 0;
        o_last_low = 0;
        forever
        begin
            @(negedge m_txd);
            repeat (BIT_CYC / 2) @(posedge i_clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CYC) @(posedge i_clk);
                o_rx_byte[i] = m_txd;
            end
            repeat (BIT_CYC) @(posedge i_clk);
            o_rx_count++;
        end
    end
    always @(posedge i_clk)
    begin
        if (m_txd === 1'b0)
            low_run <= low_run + 1;
        else
        begin
            if (low_run != 0)
                o_last_low <= low_run;
            low_run <= 0;
        end
    end
endmodule // modem_model

// ---- verif/tb.sv ----
// testbench for the serial adapter in local and remote loop-back
`timescale 1ns/10ps
module tb;
    // ========================================
    // signals
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic xtal = 1'b0;
    logic [1:0] xdiv = 2'h0;
    logic lle = 1'b0;
    logic rxc_on = 1'b1;
    logic rxd;
    logic dcd;
    logic dsr;
    logic o_txd;
    logic o_rts;
    logic o_dtr;
    logic o_irq_n;
    logic [7:0] mbyte;
    logic [7:0] rd;
    int mcount;
    int mlow;
    int failures = 0;
    int tests_run = 0;
    int n;
    // ========================================
    // clocks: 16x tick every 4 system cycles
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        xdiv <= xdiv + 2'h1;
        if (xdiv[0])
            xtal <= ~xtal;
    end
    // ========================================
    // instances
    serial_loopback_diagnostics dut
    (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_crystal_clock_input(xtal), .i_rx_clk_ext(xtal && rxc_on), .i_rxd(rxd), .i_dcd(dcd),
        .i_dsr(dsr), .o_txd(o_txd), .o_rts(o_rts), .o_dtr(o_dtr), .o_irq_n(o_irq_n)
    );
    modem_model #(.BIT_CYC(64)) modem
    (
        .i_clk(i_clk), .i_local_loop_enable(lle), .i_txd(o_txd), .i_rts(o_rts), .i_dtr(o_dtr), .o_rxd(rxd),
        .o_dcd(dcd), .o_dsr(dsr), .o_rx_byte(mbyte), .o_rx_count(mcount), .o_last_low(mlow)
    );
    // ========================================
    // tasks
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    task automatic end_sim();
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ========================================
    // watchdog
    initial
    begin
        repeat (20000) @(posedge i_clk);
        failures++;
        end_sim();
    end
    // ========================================
    // tests
    initial
    begin
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        #1;
        check("reset pins", 8'h0F, {4'h0, o_txd, o_rts, o_dtr, o_irq_n});
        rd_reg(loopback_pkg::ADDR_CMD, rd);
        check("cmd reset", loopback_pkg::CMD_RST, rd);
        rd_reg(loopback_pkg::ADDR_CTL, rd);
        check("ctl reset", loopback_pkg::CTL_RST, rd);
        // local loop: receiver on its own external clock, rx irq on
        lle <= 1'b1;
        wr(loopback_pkg::ADDR_CTL, 8'h00);
        wr(loopback_pkg::ADDR_CMD, 8'h03);
        wr(loopback_pkg::ADDR_DATA, 8'h3C);
        n = 0;
        while (o_irq_n !== 1'b0 && n < 2000)
        begin
            @(posedge i_clk);
            n++;
        end
        repeat (200) @(posedge i_clk);
        #1;
        check("loop irq_n", 8'h00, {7'h00, o_irq_n});
        check("modem count in loop", 8'h00, 8'(mcount));
        rd_reg(loopback_pkg::ADDR_STATUS, rd);
        check("loop status", 8'hD8, rd);
        rd_reg(loopback_pkg::ADDR_DATA, rd);
        check("loop data", 8'h3C, rd);
        @(posedge i_clk);
        #1;
        check("irq_n cleared", 8'h01, {7'h00, o_irq_n});
        // remote loop: echo mode, no interrupts
        lle <= 1'b0;
        rxc_on <= 1'b0;
        wr(loopback_pkg::ADDR_CTL, 8'h10);
        wr(loopback_pkg::ADDR_CMD, 8'h19);
        @(posedge i_clk);
        #1;
        check("echo rts", 8'h00, {7'h00, o_rts});
        rd_reg(loopback_pkg::ADDR_CMD, rd);
        check("cmd readback", 8'h19, rd);
        rd_reg(loopback_pkg::ADDR_CTL, rd);
        check("ctl readback", 8'h10, rd);
        modem.send(8'hA5);
        n = 0;
        while (mcount == 0 && n < 3000)
        begin
            @(posedge i_clk);
            n++;
        end
        #1;
        check("echo byte", 8'hA5, mbyte);
        check("echo count", 8'h01, 8'(mcount));
        check("bit length", 8'h40, 8'(mlow));
        check("remote irq_n", 8'h01, {7'h00, o_irq_n});
        rd_reg(loopback_pkg::ADDR_STATUS, rd);
        check("remote status", 8'h18, rd);
        rd_reg(loopback_pkg::ADDR_DATA, rd);
        check("remote data", 8'hA5, rd);
        end_sim();
    end
endmodule // tb
